/* rtl/slk_consts.svh */
// constants for the sector lock and lockdown controller
`ifndef SLK_CONSTS_SVH
`define SLK_CONSTS_SVH
`define SLK_OP_LOCKDOWN 8'h33
`define SLK_OP_FREEZE 8'h34
`define SLK_OP_WRSR1 8'h01
`define SLK_OP_PROTECT 8'h36
`define SLK_OP_UNPROTECT 8'h39
`define SLK_OP_WREN 8'h06
`define SLK_OP_WRDI 8'h04
`define SLK_OP_WRSR2 8'h31
`define SLK_OP_PROGRAM 8'h02
`define SLK_OP_ERASE64 8'hD8
`define SLK_CONFIRM 8'hD0
`define SLK_FREEZE_ADDR 24'h55AA40
`define SLK_SR1_LOCK_BIT 7
`define SLK_SR2_SLE_BIT 4
`define SLK_GLOBAL_HI 5
`define SLK_GLOBAL_LO 2
`define SLK_LOCK_TIME_NS 200
`define SLK_CLK_PERIOD_NS 40
`define SLK_LOCK_CYCLES (`SLK_LOCK_TIME_NS / `SLK_CLK_PERIOD_NS)
`endif

/* rtl/slk_pkg.sv */
// types shared by the sector lock controller
package slk_pkg;
  typedef enum logic [2:0] {
    SLK_IDLE, SLK_OPC, SLK_ADDR, SLK_DATA, SLK_DONE
  } slk_state_t;
  typedef enum logic [2:0] {
    SLK_CMD_NONE, SLK_CMD_LOCKDOWN, SLK_CMD_FREEZE, SLK_CMD_WRSR1,
    SLK_CMD_SECTOR, SLK_CMD_OTHER
  } slk_cmd_t;
endpackage

/* rtl/slk_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module slk_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= RST_VAL;
      dout <= RST_VAL;
    end else if (en) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/slk_shift.sv */
// byte assembler on sampled serial clock rising edges
`timescale 1ns/1ps
`default_nettype none
module slk_shift (
  input wire logic clk,
  input wire logic rstn,
  input wire logic en,
  input wire logic active,
  input wire logic sck_rise,
  input wire logic si,
  output logic [7:0] byte_val,
  output logic byte_stb,
  output logic [2:0] bit_cnt
);
  logic [6:0] sh_q;
  // frame end resets the bit count so a new frame starts aligned
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sh_q <= 7'h00;
      bit_cnt <= 3'h0;
      byte_val <= 8'h00;
      byte_stb <= 1'b0;
    end else if (en) begin
      byte_stb <= 1'b0;
      if (!active) begin
        bit_cnt <= 3'h0;
      end else if (sck_rise) begin
        sh_q <= {sh_q[5:0], si};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          byte_val <= {sh_q, si};
          byte_stb <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/slk_ctrl.sv */
// protection locking and sector lockdown controller
`timescale 1ns/1ps
`default_nettype none
`include "slk_consts.svh"
// Functional notes
// - hardware lock needs pin low and lock bit
// - hardware lock ignores protect, unprotect, status register 1 writes
// - unlocking status write does no global change
// - lock bit clears by power cycle or by status write under software lock
// - software lock blocks sectors, permits clearing bit
// - lock bit zero allows sector and global changes
// - setting lock bit applies global pattern too
// - pin never changes protection; bit decides
// - one persistent lockdown bit per sector
// - locked-down sectors reject program and erase
// - lockdown bits are set once only
// - lockdown needs write enable and lockdown enable
// - opcode, three address bytes, confirm, rest ignored
// - valid lockdown sets bit, clears write enable
// - bad lockdown aborts, clears only write enable
// - disabled or frozen lockdown ignored, clears latch
// - freeze uses fixed address and confirm byte
// - valid freeze freezes, clears enable permanently
// - bad freeze aborts, clears write enable only
// - status write keeps bit seven, decodes global
module slk_ctrl
  import slk_pkg::*;
#(
  parameter int SECTORS = 64,
  parameter int SEC_BITS = 6
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic POR_N,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic WP_N,
  output logic [SECTORS-1:0] SECTOR_PROTECT,
  output logic [SECTORS-1:0] SECTOR_LOCKDOWN,
  output logic LOCK_BIT,
  output logic LOCKDOWN_ENABLE,
  output logic WRITE_ENABLE,
  output logic FROZEN,
  output logic HW_LOCKED,
  output logic SW_LOCKED,
  output logic BUSY,
  output logic OP_START,
  output logic OP_REFUSED,
  output logic [SEC_BITS-1:0] OP_SECTOR
);
  import slk_pkg::*;
  initial begin
    if (SECTORS != (1 << SEC_BITS) || SEC_BITS > 8) begin
      $error("slk_ctrl: SECTORS must equal 2**SEC_BITS, SEC_BITS<=8");
    end
  end
  localparam int LOCK_CYC = (`SLK_LOCK_CYCLES < 1) ? 1 : `SLK_LOCK_CYCLES;

  logic cs_s, sck_s, si_s, wp_s, sck_d_q;
  logic sck_rise, active;
  logic [7:0] byte_val;
  logic byte_stb;
  logic [2:0] bit_cnt;
  slk_state_t state_q;
  slk_cmd_t cmd_q;
  logic [1:0] addr_idx_q;
  logic [23:0] addr_q;
  logic [7:0] data_q;
  logic got_data_q;
  logic [7:0] opc_q;
  logic cs_end;
  logic [SECTORS-1:0] prot_q;
  // nonvolatile cells start erased in simulation only
  logic [SECTORS-1:0] lockdn_q = '0;
  logic frozen_q = 1'b0;
  logic lock_q, sle_q, wel_q;
  logic [15:0] lock_cnt_q;
  logic pend_lock_q, pend_freeze_q;
  logic [SEC_BITS-1:0] pend_sec_q;
  logic hw_lock, sw_lock;
  logic [SEC_BITS-1:0] addr_sec;

  // pin inputs are asynchronous to SYS_CLK
  slk_sync #(.RST_VAL(1'b1)) u_cs (.clk(SYS_CLK), .rstn(RSTN),
    .en(CLK_EN), .din(CS_N), .dout(cs_s));
  slk_sync #(.RST_VAL(1'b0)) u_sck (.clk(SYS_CLK), .rstn(RSTN),
    .en(CLK_EN), .din(SCK), .dout(sck_s));
  slk_sync #(.RST_VAL(1'b0)) u_si (.clk(SYS_CLK), .rstn(RSTN),
    .en(CLK_EN), .din(SI), .dout(si_s));
  slk_sync #(.RST_VAL(1'b1)) u_wp (.clk(SYS_CLK), .rstn(RSTN),
    .en(CLK_EN), .din(WP_N), .dout(wp_s));

  // serial clock edge finder on the synchronised copy
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sck_d_q <= 1'b0;
    end else if (CLK_EN) begin
      sck_d_q <= sck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_d_q;
  assign active = ~cs_s;

  slk_shift u_shift (.clk(SYS_CLK), .rstn(RSTN), .en(CLK_EN),
    .active(active), .sck_rise(sck_rise), .si(si_s),
    .byte_val(byte_val), .byte_stb(byte_stb), .bit_cnt(bit_cnt));

  // frame end: chip select seen high while a frame was open
  assign cs_end = cs_s && (state_q != SLK_IDLE);
  assign hw_lock = ~wp_s & lock_q;
  assign sw_lock = wp_s & lock_q;
  // 64-Kbyte sectors: the sector index starts at address bit 16
  assign addr_sec = addr_q[16 +: SEC_BITS];

  // command framing: opcode, three address bytes (none for status writes), one data byte
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= SLK_IDLE;
      cmd_q <= SLK_CMD_NONE;
      opc_q <= 8'h00;
      addr_idx_q <= 2'h0;
      addr_q <= 24'h000000;
      data_q <= 8'h00;
      got_data_q <= 1'b0;
    end else if (CLK_EN) begin
      if (cs_end) begin
        state_q <= SLK_IDLE;
      end else if (active && state_q == SLK_IDLE) begin
        state_q <= SLK_OPC;
        got_data_q <= 1'b0;
        addr_idx_q <= 2'h0;
      end else if (byte_stb) begin
        case (state_q)
          SLK_OPC: begin
            opc_q <= byte_val;
            case (byte_val)
              `SLK_OP_LOCKDOWN: cmd_q <= SLK_CMD_LOCKDOWN;
              `SLK_OP_FREEZE: cmd_q <= SLK_CMD_FREEZE;
              `SLK_OP_WRSR1: cmd_q <= SLK_CMD_WRSR1;
              `SLK_OP_PROTECT, `SLK_OP_UNPROTECT, `SLK_OP_PROGRAM,
              `SLK_OP_ERASE64: cmd_q <= SLK_CMD_SECTOR;
              default: cmd_q <= SLK_CMD_OTHER;
            endcase
            if (byte_val == `SLK_OP_WRSR1 ||
                byte_val == `SLK_OP_WRSR2) begin
              state_q <= SLK_DATA;
            end else begin
              state_q <= SLK_ADDR;
            end
          end
          SLK_ADDR: begin
            addr_q <= {addr_q[15:0], byte_val};
            addr_idx_q <= addr_idx_q + 2'h1;
            if (addr_idx_q == 2'h2) begin
              state_q <= SLK_DATA;
            end
          end
          SLK_DATA: begin
            // only the first data byte counts, later ones ignored
            data_q <= byte_val;
            got_data_q <= 1'b1;
            state_q <= SLK_DONE;
          end
          SLK_DONE: state_q <= SLK_DONE;
          default: state_q <= SLK_IDLE;
        endcase
      end
    end
  end

  // checks applied at chip select rise
  logic aligned, addr_done, conf_ok, ld_ok, fz_ok, ld_allowed;
  assign aligned = (bit_cnt == 3'h0);
  // all address bytes in once framing has reached the data phase
  assign addr_done = (state_q == SLK_DATA) || (state_q == SLK_DONE);
  assign conf_ok = addr_done && (data_q == `SLK_CONFIRM);
  assign ld_allowed = wel_q && sle_q && !frozen_q;
  assign ld_ok = cs_end && aligned && conf_ok && ld_allowed &&
                 (opc_q == `SLK_OP_LOCKDOWN) && !BUSY;
  assign fz_ok = cs_end && aligned && conf_ok && wel_q && sle_q &&
                 (addr_q == `SLK_FREEZE_ADDR) && (opc_q == `SLK_OP_FREEZE)
                 && !BUSY;

  // lock-time counter: lockdown and freeze take effect on completion
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lock_cnt_q <= 16'h0000;
      pend_lock_q <= 1'b0;
      pend_freeze_q <= 1'b0;
      pend_sec_q <= '0;
      BUSY <= 1'b0;
    end else if (CLK_EN) begin
      if (ld_ok || fz_ok) begin
        lock_cnt_q <= 16'(LOCK_CYC);
        pend_lock_q <= ld_ok;
        pend_freeze_q <= fz_ok;
        pend_sec_q <= addr_sec;
        BUSY <= 1'b1;
      end else if (BUSY) begin
        lock_cnt_q <= lock_cnt_q - 16'h0001;
        if (lock_cnt_q == 16'h0001) begin
          BUSY <= 1'b0;
          pend_lock_q <= 1'b0;
          pend_freeze_q <= 1'b0;
        end
      end
    end
  end

  // lockdown bits and freeze flag only ever go to one; POR_N does not
  // touch them since they model nonvolatile cells
  always_ff @(posedge SYS_CLK) begin
    if (CLK_EN) begin
      if (BUSY && lock_cnt_q == 16'h0001 && pend_lock_q) begin
        lockdn_q[pend_sec_q] <= 1'b1;
      end
      if (BUSY && lock_cnt_q == 16'h0001 && pend_freeze_q) begin
        frozen_q <= 1'b1;
      end
    end
  end

  // write enable latch and lockdown enable bit
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wel_q <= 1'b0;
      sle_q <= 1'b0;
    end else if (CLK_EN) begin
      if (BUSY && lock_cnt_q == 16'h0001 && pend_freeze_q) begin
        sle_q <= 1'b0;
      end else if (cs_end && aligned && got_data_q &&
                   opc_q == `SLK_OP_WRSR2 && !frozen_q && wel_q) begin
        sle_q <= data_q[`SLK_SR2_SLE_BIT];
      end
      if (cs_end) begin
        if (opc_q == `SLK_OP_WREN && aligned) begin
          wel_q <= 1'b1;
        end else if (cmd_q != SLK_CMD_OTHER || opc_q == `SLK_OP_WRDI ||
                     opc_q == `SLK_OP_WRSR2) begin
          // any lockdown or freeze attempt, good or bad, clears latch
          wel_q <= 1'b0;
        end
      end
    end
  end

  // status write, sector protect and global operations
  logic wrsr_ok, lock_set, lock_clr, glob_un, glob_pr, sec_ok;
  assign wrsr_ok = cs_end && aligned && got_data_q && wel_q &&
                   opc_q == `SLK_OP_WRSR1 && !hw_lock;
  assign lock_set = wrsr_ok && !lock_q &&
                    data_q[`SLK_SR1_LOCK_BIT];
  assign lock_clr = wrsr_ok && lock_q && sw_lock &&
                    !data_q[`SLK_SR1_LOCK_BIT];
  assign glob_un = data_q[`SLK_GLOBAL_HI:`SLK_GLOBAL_LO] == 4'h0;
  assign glob_pr = data_q[`SLK_GLOBAL_HI:`SLK_GLOBAL_LO] == 4'hF;
  assign sec_ok = cs_end && aligned && addr_done && wel_q && !lock_q &&
                  (opc_q == `SLK_OP_PROTECT ||
                   opc_q == `SLK_OP_UNPROTECT);

  // lock bit comes up zero only at power-on, not at every reset
  always_ff @(posedge SYS_CLK or negedge POR_N) begin
    if (!POR_N) begin
      lock_q <= 1'b0;
      prot_q <= '1;
    end else if (CLK_EN) begin
      if (lock_set || lock_clr) begin
        lock_q <= data_q[`SLK_SR1_LOCK_BIT];
      end
      // global only when lock bit was zero before this write
      if (wrsr_ok && !lock_q && glob_un) begin
        prot_q <= '0;
      end else if (wrsr_ok && !lock_q && glob_pr) begin
        prot_q <= '1;
      end else if (sec_ok) begin
        prot_q[addr_sec] <= (opc_q == `SLK_OP_PROTECT);
      end
    end
  end

  // array operation gate: pin level plays no part here
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      OP_START <= 1'b0;
      OP_REFUSED <= 1'b0;
      OP_SECTOR <= '0;
    end else if (CLK_EN) begin
      OP_START <= 1'b0;
      OP_REFUSED <= 1'b0;
      if (cs_end && aligned && addr_done && wel_q &&
          (opc_q == `SLK_OP_PROGRAM || opc_q == `SLK_OP_ERASE64)) begin
        OP_SECTOR <= addr_sec;
        if (lockdn_q[addr_sec] || prot_q[addr_sec] || BUSY) begin
          OP_REFUSED <= 1'b1;
        end else begin
          OP_START <= 1'b1;
        end
      end
    end
  end

  // registered status outputs
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SECTOR_PROTECT <= '0;
      SECTOR_LOCKDOWN <= '0;
      LOCK_BIT <= 1'b0;
      LOCKDOWN_ENABLE <= 1'b0;
      WRITE_ENABLE <= 1'b0;
      FROZEN <= 1'b0;
      HW_LOCKED <= 1'b0;
      SW_LOCKED <= 1'b0;
    end else if (CLK_EN) begin
      SECTOR_PROTECT <= prot_q;
      SECTOR_LOCKDOWN <= lockdn_q;
      LOCK_BIT <= lock_q;
      LOCKDOWN_ENABLE <= sle_q;
      WRITE_ENABLE <= wel_q;
      FROZEN <= frozen_q;
      HW_LOCKED <= hw_lock;
      SW_LOCKED <= sw_lock;
    end
  end

  // assertions
  property p_hwfreeze;
    @(posedge SYS_CLK) disable iff (!RSTN || !POR_N)
    (CLK_EN && hw_lock) |=> ($stable(prot_q) && lock_q);
  endproperty
  a_hwfreeze: assert property (p_hwfreeze)
    else $error("protection changed under hardware lock");
  property p_nounlock;
    @(posedge SYS_CLK) disable iff (!RSTN)
    lockdn_q != '0 |=> (lockdn_q & $past(lockdn_q)) == $past(lockdn_q);
  endproperty
  a_nounlock: assert property (p_nounlock)
    else $error("lockdown bit cleared");
  property p_refuse;
    @(posedge SYS_CLK) disable iff (!RSTN)
    OP_START |-> !lockdn_q[OP_SECTOR];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("operation started on locked sector");
  property p_weclr;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && cs_end && opc_q == `SLK_OP_LOCKDOWN) |=> !wel_q;
  endproperty
  a_weclr: assert property (p_weclr)
    else $error("write enable kept after lockdown");
  property p_ldgate;
    @(posedge SYS_CLK) disable iff (!RSTN)
    ld_ok |-> (wel_q && sle_q && !frozen_q);
  endproperty
  a_ldgate: assert property (p_ldgate)
    else $error("lockdown without enables");
  property p_locktime;
    @(posedge SYS_CLK) disable iff (!RSTN)
    (CLK_EN && ld_ok) |-> ##[1:300] lockdn_q[pend_sec_q];
  endproperty
  a_locktime: assert property (p_locktime)
    else $error("lockdown not done in lock time");
  property p_frzsle;
    @(posedge SYS_CLK) disable iff (!RSTN)
    frozen_q && !BUSY |-> !sle_q;
  endproperty
  a_frzsle: assert property (p_frzsle)
    else $error("enable bit set while frozen");
  property p_hwdef;
    @(posedge SYS_CLK) disable iff (!RSTN)
    CLK_EN |=> HW_LOCKED == $past(hw_lock);
  endproperty
  a_hwdef: assert property (p_hwdef)
    else $error("hardware lock status wrong");
  c_lockdown: cover property (@(posedge SYS_CLK) ld_ok);
  c_freeze: cover property (@(posedge SYS_CLK) fz_ok);
  c_refused: cover property (@(posedge SYS_CLK) OP_REFUSED);
endmodule
`default_nettype wire

/* sim/slk_host_model.sv */
// serial host model that frames flash commands onto the pins
`timescale 1ns/1ps
`default_nettype none
module slk_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic si
);
  // idle: deselected, clock parked low between frames
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic nwait(input int n);
    repeat (n) @(negedge clk);
  endtask
  // whole bytes msb first, then tail stray bits to end off a boundary;
  // half serial period is 4 system cycles, above the 3-cycle minimum
  task automatic frame(input logic [7:0] q[$], input int tail);
    logic [7:0] b;
    nwait(1);
    cs_n = 1'b0;
    for (int i = 0; i < q.size() * 8 + tail; i++) begin
      b = (i / 8 < q.size()) ? q[i / 8] : 8'hA5;
      si = b[7 - i % 8];
      nwait(4);
      sck = 1'b1;
      nwait(4);
      sck = 1'b0;
    end
    nwait(4);
    cs_n = 1'b1;
    si = ~si; // released line must not look like the last bit
    nwait(8);
  endtask
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the sector lock and lockdown controller
`timescale 1ns/1ps
`default_nettype none
`include "slk_consts.svh"
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic por_n = 1'b0;
  logic wp_n = 1'b1;
  logic cs_n, sck, si;
  logic [63:0] prot, lkd;
  logic lock, lockdown_enable_bit, write_enable_latch, frz, hwl, swl, busy, op_go, op_no;
  logic [5:0] op_sec;
  int n_fail = 0;
  int n_compared = 0;
  int n_go = 0;
  int n_no = 0;
  int cyc = 0;
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  slk_host_model host (.clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si));
  slk_ctrl uut (
    .SYS_CLK(sys_clk), .RSTN(rstn), .CLK_EN(1'b1), .POR_N(por_n),
    .CS_N(cs_n), .SCK(sck), .SI(si), .WP_N(wp_n),
    .SECTOR_PROTECT(prot), .SECTOR_LOCKDOWN(lkd), .LOCK_BIT(lock),
    .LOCKDOWN_ENABLE(lockdown_enable_bit), .WRITE_ENABLE(write_enable_latch), .FROZEN(frz),
    .HW_LOCKED(hwl), .SW_LOCKED(swl), .BUSY(busy), .OP_START(op_go),
    .OP_REFUSED(op_no), .OP_SECTOR(op_sec)
  );
  // one-cycle pulses are counted where they stand; hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (op_go === 1'b1) n_go <= n_go + 1;
    if (op_no === 1'b1) n_no <= n_no + 1;
    if (cyc == 40000) begin
      n_fail++;
      wrap_up();
    end
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // fixed settle covers the answer delay plus the lock time
  task automatic cmd(input logic [7:0] q[$], input int tail = 0);
    host.frame(q, tail);
    repeat (16) @(negedge sys_clk);
  endtask
  task automatic wcmd(input logic [7:0] q[$], input int tail = 0);
    cmd('{`SLK_OP_WREN});
    cmd(q, tail);
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    por_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(lock, 1'b0);
    chk(lkd, 64'h0);
    wcmd('{`SLK_OP_WRSR1, 8'h00});
    chk(prot, 64'h0);
    wcmd('{`SLK_OP_PROTECT, 8'h03, 8'h12, 8'h34});
    chk(prot, 64'h8);
    wcmd('{`SLK_OP_WRSR1, 8'h0C});
    chk({lock, prot}, {1'b0, 64'h8});
    // hardware lock: pin low, lock bit set with global protect
    wp_n = 1'b0;
    wcmd('{`SLK_OP_WRSR1, 8'hFC});
    chk({lock, hwl, swl}, 3'b110);
    chk(prot, '1);
    wcmd('{`SLK_OP_UNPROTECT, 8'h03, 8'h00, 8'h00});
    wcmd('{`SLK_OP_WRSR1, 8'h00});
    chk({lock, prot}, {1'b1, 64'hFFFFFFFFFFFFFFFF});
    // software lock: pin high
    wp_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    chk({lock, hwl, swl}, 3'b101);
    wcmd('{`SLK_OP_UNPROTECT, 8'h03, 8'h00, 8'h00});
    chk(prot, '1);
    wcmd('{`SLK_OP_WRSR1, 8'h00});
    chk({lock, prot}, {1'b0, 64'hFFFFFFFFFFFFFFFF});
    wp_n = 1'b0;
    wcmd('{`SLK_OP_UNPROTECT, 8'h03, 8'h00, 8'h00});
    chk({hwl, prot[3], prot[2]}, 3'b001);
    wp_n = 1'b1;
    // lockdown attempts
    wcmd('{`SLK_OP_LOCKDOWN, 8'h05, 8'hAB, 8'hCD, `SLK_CONFIRM});
    chk({lkd[5], write_enable_latch}, 2'b00);
    wcmd('{`SLK_OP_WRSR2, 8'h10});
    chk(lockdown_enable_bit, 1'b1);
    cmd('{`SLK_OP_LOCKDOWN, 8'h05, 8'hAB, 8'hCD, `SLK_CONFIRM});
    chk(lkd, 64'h0);
    cmd('{`SLK_OP_WREN});
    chk(write_enable_latch, 1'b1);
    cmd('{`SLK_OP_LOCKDOWN, 8'h05, 8'hAB, 8'hCD, 8'hD1});
    chk({lkd[5], lockdown_enable_bit, write_enable_latch}, 3'b010);
    wcmd('{`SLK_OP_LOCKDOWN, 8'h05, 8'hAB, 8'hCD, `SLK_CONFIRM}, 3);
    chk({lkd[5], lockdown_enable_bit, write_enable_latch}, 3'b010);
    wcmd('{`SLK_OP_LOCKDOWN, 8'h05, 8'hAB});
    chk({lkd[5], lockdown_enable_bit, write_enable_latch}, 3'b010);
    wcmd('{`SLK_OP_LOCKDOWN, 8'h05, 8'hAB, 8'hCD, `SLK_CONFIRM, 8'h00});
    chk({lkd, write_enable_latch}, {64'h20, 1'b0});
    // program into the locked sector, erase unprotected sector 3
    wcmd('{`SLK_OP_PROGRAM, 8'h05, 8'h00, 8'h10, 8'h5A});
    wcmd('{`SLK_OP_ERASE64, 8'h03, 8'h00, 8'h00});
    chk({n_no[3:0], n_go[3:0]}, 8'h11);
    chk({busy, op_sec}, 7'h03);
    // freeze: wrong address first, then the real one
    wcmd('{`SLK_OP_FREEZE, 8'h55, 8'hAA, 8'h41, `SLK_CONFIRM});
    chk({frz, lockdown_enable_bit, write_enable_latch}, 3'b010);
    wcmd('{`SLK_OP_FREEZE, 8'h55, 8'hAA, 8'h40, `SLK_CONFIRM, 8'hFF});
    chk({frz, lockdown_enable_bit, write_enable_latch}, 3'b100);
    wcmd('{`SLK_OP_WRSR2, 8'h10});
    wcmd('{`SLK_OP_LOCKDOWN, 8'h07, 8'h00, 8'h00, `SLK_CONFIRM});
    chk({lkd, lockdown_enable_bit, write_enable_latch}, {64'h20, 2'b00});
    // set lock bit with pin low, then power cycle
    wp_n = 1'b0;
    wcmd('{`SLK_OP_WRSR1, 8'h80});
    chk(lock, 1'b1);
    rstn = 1'b0;
    por_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    por_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk({lock, frz, lkd}, {2'b01, 64'h20});
    wrap_up();
  end
endmodule
`default_nettype wire
